/* hw/i2c_config_reader.sv */
// Notes on behaviour
// (R1) Read needs command transfer then data transfer
// (R2) Read only when direction bit is one
// (R3) Valid read command fetches register into buffer
// (R4) Buffer sent most significant byte first
// (R5) Past four bytes, sequence restarts at top
// (R6) Repeated start may merge both transfers
// (R7) Command transfer: address, reserved, four bytes
// (R8) Data transfer returns bytes, no reserved byte
// (R9) Virtual space bit honoured only in bridging mode
// (R10) Port selector from byte1[1:0], byte2[7]
// (R11) Address from byte2[1:0], byte3; enables byte2[5:2]
// (R12) Master clears reserved command bits
// (R13) Target address 70h with straps on low bits
// (R14) Opcode 011b write, 100b read, others reserved
// (R15) Master uses port selectors 0 to 4 only
// (R16) Addresses dword aligned, low bits zero
// (R17) Acknowledge accepted bytes; buffer held until replaced
// (R18) Invalid command leaves buffer and registers untouched
`timescale 1ns/100ps
`default_nettype none
module i2c_config_reader
  import i2c_rd_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)(
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  input  wire logic [STRAP_W-1:0]  addr_strap,
  input  wire logic                isolated_host_bridging_mode,
  output logic                     reg_rd_req,
  output logic [2:0]               reg_port_sel,
  output logic [11:0]              reg_addr,
  output logic [3:0]               reg_byte_en,
  output logic                     reg_virtual_side_register_space,
  input  wire logic [WORD_W-1:0]   reg_rd_data,
  input  wire logic                reg_rd_valid,
  output logic                     reg_rd_ready
);
  typedef struct packed {
    logic                scl_s1;
    logic                scl_s2;
    logic                scl_d;
    logic                sda_s1;
    logic                sda_s2;
    logic                sda_d;
    logic [STRAP_W-1:0]  strap_s1;
    logic [STRAP_W-1:0]  strap_s2;
    bus_state_t          st;
    logic [3:0]          bitcnt;
    logic [2:0]          byte_idx;
    logic [7:0]          shreg;
    logic                rw;
    logic [3:0][7:0]     cmd;
    logic [1:0]          rd_idx;
    logic [WORD_W-1:0]   buffer;
    logic                sda_low;
    logic                req;
    logic [2:0]          port;
    logic [11:0]         addr;
    logic [3:0]          be;
    logic                virt;
  } state_t;

  state_t     q_reg;
  state_t     q_next;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic [6:0] own_addr;
  logic [7:0] tx_byte;
  logic [2:0] new_port;
  logic       cmd_ok;
  logic       tx_busy;

  word_stream_if #(.WIDTH(WORD_W)) push_s ();
  word_stream_if #(.WIDTH(WORD_W)) pop_s ();

  // Fetched words queue here so the core waits only when the queue is full
  word_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_fifo (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .push    (push_s),
    .pop     (pop_s)
  );

  assign push_s.valid = reg_rd_valid;
  assign push_s.data  = reg_rd_data;
  assign reg_rd_ready = push_s.ready;

  // Buffer is not swapped while a byte sequence is on the wire
  assign tx_busy     = (q_reg.st == ST_TX) || (q_reg.st == ST_TX_ACK);
  assign pop_s.ready = ~tx_busy; // R17

  assign scl_rise   = q_reg.scl_s2 & ~q_reg.scl_d;
  assign scl_fall   = ~q_reg.scl_s2 & q_reg.scl_d;
  assign start_seen = q_reg.scl_s2 & q_reg.scl_d & q_reg.sda_d & ~q_reg.sda_s2;
  assign stop_seen  = q_reg.scl_s2 & q_reg.scl_d & ~q_reg.sda_d & q_reg.sda_s2;
  assign own_addr   = {TARGET_ADDR_BASE[6:STRAP_W], q_reg.strap_s2}; // R13

  always_comb
  begin
    case (q_reg.rd_idx) // R4
      2'h0:    tx_byte = q_reg.buffer[31:24];
      2'h1:    tx_byte = q_reg.buffer[23:16];
      2'h2:    tx_byte = q_reg.buffer[15:8];
      default: tx_byte = q_reg.buffer[7:0];
    endcase
  end

  assign new_port = {q_reg.cmd[1][PORT_HI_LSB +: 2], q_reg.cmd[2][PORT_LO_BIT]}; // R10
  assign cmd_ok   = (q_reg.cmd[0][OPCODE_LSB +: 3] == OP_READ)                 // R14
                  && (new_port <= PORT_SEL_MAX)                                 // R18
                  && (!q_reg.cmd[1][VIRT_BIT] || isolated_host_bridging_mode); // R9

  always_comb
  begin
    q_next          = q_reg;
    q_next.req      = 1'b0;
    q_next.scl_s1   = scl_in;
    q_next.scl_s2   = q_reg.scl_s1;
    q_next.scl_d    = q_reg.scl_s2;
    q_next.sda_s1   = sda_in;
    q_next.sda_s2   = q_reg.sda_s1;
    q_next.sda_d    = q_reg.sda_s2;
    q_next.strap_s1 = addr_strap;
    q_next.strap_s2 = q_reg.strap_s1;
    if (pop_s.valid && pop_s.ready)
      q_next.buffer = pop_s.data; // R3
    if (start_seen)
    begin
      // Repeated start restarts address decoding at once
      q_next.st       = ST_RX; // R6
      q_next.byte_idx = '0;
      q_next.bitcnt   = '0;
      q_next.sda_low  = 1'b0;
    end
    else if (stop_seen)
    begin
      q_next.st      = ST_IDLE;
      q_next.sda_low = 1'b0;
    end
    else
    begin
      case (q_reg.st)
        ST_IDLE:
        begin
          q_next.sda_low = 1'b0;
        end
        ST_RX:
        begin
          if (scl_rise && q_reg.bitcnt < BITS_PER_BYTE)
          begin
            q_next.shreg  = {q_reg.shreg[6:0], q_reg.sda_s2};
            q_next.bitcnt = q_reg.bitcnt + 1'b1;
          end
          if (scl_fall && q_reg.bitcnt == BITS_PER_BYTE)
          begin
            q_next.st       = ST_IDLE;
            q_next.byte_idx = (q_reg.byte_idx == 3'h7) ? q_reg.byte_idx : q_reg.byte_idx + 1'b1;
            if (q_reg.byte_idx == '0)
            begin
              q_next.rw     = q_reg.shreg[0]; // R2
              q_next.rd_idx = '0;
              if (q_reg.shreg[7:1] == own_addr)
              begin
                q_next.st      = ST_ACK; // R17
                q_next.sda_low = 1'b1;
              end
            end
            else if (q_reg.byte_idx <= CMD_LAST_IDX)
            begin
              q_next.st      = ST_ACK; // R17
              q_next.sda_low = 1'b1;
              if (q_reg.byte_idx >= CMD_FIRST_IDX)
                q_next.cmd[2'(q_reg.byte_idx - CMD_FIRST_IDX)] = q_reg.shreg; // R1
              if (q_reg.byte_idx == CMD_LAST_IDX && cmd_ok) // R18
              begin
                q_next.req  = 1'b1; // R3
                q_next.port = new_port;
                q_next.addr = {q_reg.cmd[2][ADDR_HI_LSB +: 2], q_reg.shreg,
                               DWORD_LOW_BITS}; // R11 R16
                q_next.be   = q_reg.cmd[2][BE_LSB +: 4]; // R11
                q_next.virt = q_reg.cmd[1][VIRT_BIT];
              end
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            q_next.bitcnt = '0;
            if (q_reg.rw)
            begin
              // Data follows the address directly
              q_next.st      = ST_TX; // R8
              q_next.sda_low = ~tx_byte[7];
            end
            else
            begin
              q_next.st      = ST_RX;
              q_next.sda_low = 1'b0;
            end
          end
        end
        ST_TX:
        begin
          if (scl_rise && q_reg.bitcnt < BITS_PER_BYTE)
            q_next.bitcnt = q_reg.bitcnt + 1'b1;
          if (scl_fall)
          begin
            if (q_reg.bitcnt == BITS_PER_BYTE)
            begin
              q_next.sda_low = 1'b0;
              q_next.st      = ST_TX_ACK;
            end
            else
              q_next.sda_low = ~tx_byte[3'(4'h7 - q_reg.bitcnt)]; // R4
          end
        end
        ST_TX_ACK:
        begin
          if (scl_rise)
          begin
            if (q_reg.sda_s2)
              q_next.st = ST_IDLE;
            else
            begin
              q_next.st     = ST_TX;
              q_next.bitcnt = '0;
              q_next.rd_idx = q_reg.rd_idx + 1'b1; // R5
            end
          end
        end
        default:
        begin
          q_next.st = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q_reg        <= '0;
      q_reg.scl_s1 <= 1'b1;
      q_reg.scl_s2 <= 1'b1;
      q_reg.scl_d  <= 1'b1;
      q_reg.sda_s1 <= 1'b1;
      q_reg.sda_s2 <= 1'b1;
      q_reg.sda_d  <= 1'b1;
      q_reg.st     <= ST_IDLE;
    end
    else
      q_reg <= q_next;
  end

  // Open drain: only ever pulls low
  assign sda_out                         = 1'b0;
  assign sda_oe                          = q_reg.sda_low;
  assign reg_rd_req                      = q_reg.req;
  assign reg_port_sel                    = q_reg.port;
  assign reg_addr                        = q_reg.addr;
  assign reg_byte_en                     = q_reg.be;
  assign reg_virtual_side_register_space = q_reg.virt;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  sequence read_addr_acked;
    q_reg.st == ST_ACK && q_reg.rw && q_reg.byte_idx == 3'h1 && scl_fall;
  endsequence

  sequence last_cmd_done;
    q_reg.st == ST_RX && scl_fall && q_reg.bitcnt == 4'h8 && q_reg.byte_idx == 3'h5;
  endsequence

  port_select_a: assert property (reg_rd_req |-> reg_port_sel ==
      {$past(q_reg.cmd[1][1:0]), $past(q_reg.cmd[2][7])})
    else $error("port selector mismatch"); // R10
  addr_map_a: assert property (reg_rd_req |-> reg_addr[1:0] == 2'h0
      && reg_addr[11:10] == $past(q_reg.cmd[2][1:0]) && reg_byte_en == $past(q_reg.cmd[2][5:2]))
    else $error("address or enables mismatch"); // R11
  invalid_cmd_a: assert property (last_cmd_done and !cmd_ok |=> !reg_rd_req)
    else $error("fetch on invalid command"); // R18
  fetch_issue_a: assert property (last_cmd_done and cmd_ok |=> reg_rd_req && reg_port_sel <= 3'h4)
    else $error("valid read not fetched"); // R3
  virt_gate_a: assert property (reg_rd_req && reg_virtual_side_register_space
      |-> $past(isolated_host_bridging_mode))
    else $error("virtual space without bridging mode"); // R9
  buffer_hold_a: assert property (!$stable(q_reg.buffer) |-> $past(pop_s.valid && !tx_busy))
    else $error("buffer changed without new fetch"); // R17
  direct_data_a: assert property (read_addr_acked |=> q_reg.st == ST_TX
      && sda_oe == ~q_reg.buffer[31] ##1 q_reg.rd_idx == 2'h0)
    else $error("read data not sent first from top byte"); // R8
  byte_wrap_a: assert property (q_reg.st == ST_TX_ACK && scl_rise && !q_reg.sda_s2
      && q_reg.rd_idx == 2'h3 |=> q_reg.rd_idx == 2'h0 && q_reg.st == ST_TX)
    else $error("byte sequence did not wrap"); // R5
  tx_bit_a: assert property (q_reg.st == ST_TX && scl_rise && q_reg.bitcnt < 4'h8
      |-> sda_oe == ~tx_byte[3'(4'h7 - q_reg.bitcnt)])
    else $error("wrong data bit on the wire"); // R4
  strap_addr_a: assert property (own_addr == {4'he, q_reg.strap_s2})
    else $error("target address wrong"); // R13
  restart_a: assert property (start_seen |=> q_reg.st == ST_RX && q_reg.byte_idx == 3'h0)
    else $error("repeated start not honoured"); // R6
  write_dir_a: assert property (q_reg.st == ST_ACK && !q_reg.rw && scl_fall
      |=> q_reg.st == ST_RX && !sda_oe)
    else $error("write direction sent data"); // R2
endmodule
`default_nettype wire

/* hw/i2c_rd_pkg.sv */
`default_nettype none
package i2c_rd_pkg;
  localparam int        WORD_W          = 32;
  localparam int        FIFO_DEPTH      = 32;
  localparam logic [6:0] TARGET_ADDR_BASE = 7'h70;
  localparam int        STRAP_W         = 3;
  localparam logic [2:0] OP_WRITE        = 3'h3;
  localparam logic [2:0] OP_READ         = 3'h4;
  localparam logic [2:0] PORT_SEL_MAX    = 3'h4;
  localparam logic [2:0] CMD_FIRST_IDX   = 3'h2;
  localparam logic [2:0] CMD_LAST_IDX    = 3'h5;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam int        OPCODE_LSB      = 0;
  localparam int        VIRT_BIT        = 2;
  localparam int        PORT_HI_LSB     = 0;
  localparam int        PORT_LO_BIT     = 7;
  localparam int        BE_LSB          = 2;
  localparam int        ADDR_HI_LSB     = 0;
  localparam logic [1:0] DWORD_LOW_BITS  = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TX_ACK
  } bus_state_t;
endpackage
`default_nettype wire

/* hw/word_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module word_fifo
  import i2c_rd_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
)(
  input  wire logic   sys_clk,
  input  wire logic   nrst,
  word_stream_if.sink push,
  word_stream_if.src  pop
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [CW-1:0]               cnt;
  } fifo_state_t;

  fifo_state_t q_reg;
  fifo_state_t q_next;
  logic        do_push;
  logic        do_pop;

  assign push.ready = (q_reg.cnt != FULL_CNT);
  assign pop.valid  = (q_reg.cnt != '0);
  assign pop.data   = q_reg.mem[q_reg.rd];
  assign do_push    = push.valid & push.ready;
  assign do_pop     = pop.valid & pop.ready;

  always_comb
  begin
    q_next = q_reg;
    if (do_push)
    begin
      q_next.mem[q_reg.wr] = push.data;
      q_next.wr = (q_reg.wr == LAST_PTR) ? '0 : q_reg.wr + 1'b1;
    end
    if (do_pop)
    begin
      q_next.rd = (q_reg.rd == LAST_PTR) ? '0 : q_reg.rd + 1'b1;
    end
    case ({do_push, do_pop})
      2'b10:   q_next.cnt = q_reg.cnt + 1'b1;
      2'b01:   q_next.cnt = q_reg.cnt - 1'b1;
      default: q_next.cnt = q_reg.cnt;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      q_reg <= '0;
    else
      q_reg <= q_next;
  end
endmodule
`default_nettype wire

/* hw/word_stream_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface word_stream_if #(parameter int WIDTH = 32);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src  (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

/* verif/bus_host.sv */
`timescale 1ns/100ps
`default_nettype none
module bus_host (
  output logic      scl,
  output logic      sda_rel,
  input  wire logic sda
);
  event       got;
  logic [7:0] got_d;
  logic       s;
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // Data moves mid-low so the target's synchronisers see it settled
  task automatic bit_io(input logic b);
    #50 sda_rel = b;
    #50 scl = 1'b1;
    #50 s = sda;
    #50 scl = 1'b0;
  endtask
  task automatic start;
    #50 sda_rel = 1'b1;
    #50 scl = 1'b1;
    #50 sda_rel = 1'b0;
    #50 scl = 1'b0;
  endtask
  // Clock stands high between frames
  task automatic stop;
    #50 sda_rel = 1'b0;
    #50 scl = 1'b1;
    #50 sda_rel = 1'b1;
    #50;
  endtask
  task automatic wr(input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i]);
    bit_io(1'b1);
    got_d = {7'h0, s};
    -> got;
  endtask
  task automatic rd(input logic last);
    logic [7:0] d;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1);
      d[i] = s;
    end
    // Refusal on the last byte stops the target sending
    bit_io(last);
    got_d = d;
    -> got;
  endtask
  task automatic cmd_frame(input logic [6:0] a, input logic [31:0] c);
    start();
    wr({a, 1'b0});
    wr(8'h00);
    for (int i = 3; i >= 0; i--)
      wr(c[8*i+:8]);
  endtask
  task automatic rd_frame(input logic [6:0] a, input int n);
    start();
    wr({a, 1'b1});
    for (int i = 0; i < n; i++)
      rd(i == n - 1);
    stop();
  endtask
endmodule
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("Error at %0t: got %h, expected %h", $time, (g), (e)); \
    end \
  end
module tb_top
  import i2c_rd_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        scl;
  logic        sda_rel;
  wire         sda;
  logic        sda_oe;
  logic        sda_out;
  logic [2:0]  strap = 3'h0;
  logic        mode = 1'b0;
  logic        rd_req;
  logic [2:0]  port;
  logic [11:0] addr;
  logic [3:0]  be;
  logic        virt;
  logic [31:0] word = 32'h0;
  logic        valid = 1'b0;
  logic        ready;
  logic [31:0] exp_q[$];
  int          bad_count = 0;
  int          tests_run = 0;
  logic [31:0] core_w;
  logic [31:0] c;
  logic [31:0] last;
  logic [6:0]  ta;
  logic [2:0]  p;
  logic        ok;
  logic        ok_c;

  always #12.5 sys_clk = ~sys_clk;
  // Open drain with pull-up
  assign sda = sda_rel & ~sda_oe;

  bus_host u_host (
    .scl     (scl),
    .sda_rel (sda_rel),
    .sda     (sda)
  );
  i2c_config_reader #(.DEPTH(2)) u_i2c_config_reader (
    .sys_clk                         (sys_clk),
    .nrst                            (nrst),
    .scl_in                          (scl),
    .sda_in                          (sda),
    .sda_out                         (sda_out),
    .sda_oe                          (sda_oe),
    .addr_strap                      (strap),
    .isolated_host_bridging_mode     (mode),
    .reg_rd_req                      (rd_req),
    .reg_port_sel                    (port),
    .reg_addr                        (addr),
    .reg_byte_en                     (be),
    .reg_virtual_side_register_space (virt),
    .reg_rd_data                     (word),
    .reg_rd_valid                    (valid),
    .reg_rd_ready                    (ready)
  );

  task automatic end_sim;
    if (bad_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic note(input logic [31:0] v);
    exp_q.push_back(v);
  endtask
  task automatic take(input logic [31:0] g);
    logic [31:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hdead_beef;
    `CHK(g, e)
  endtask
  // Valid held until accepted or tries run out
  task automatic push(input logic [31:0] w, input int tries, output logic acc);
    @(negedge sys_clk);
    word = w;
    valid = 1'b1;
    acc = 1'b0;
    for (int i = 0; i < tries && !acc; i++)
    begin
      #1 acc = ready;
      @(negedge sys_clk);
    end
    valid = 1'b0;
    word = ~w;
  endtask
  function automatic logic [31:0] flds(input logic [31:0] v);
    return {12'h0, v[18], v[17:16], v[15], v[13:10], v[9:8], v[7:0], 2'b00};
  endfunction
  task automatic read_cmd(input logic [31:0] v, input logic good, input logic mrg);
    repeat (5) note(32'h0);
    if (good) note(flds(v));
    note(32'h0);
    u_host.cmd_frame(ta, v);
    if (!mrg) u_host.stop();
  endtask
  task automatic read_data(input logic [31:0] w, input int n);
    note(32'h0);
    for (int k = 0; k < n; k++)
      note({24'h0, w[8*(3-k%4)+:8]});
    u_host.rd_frame(ta, n);
  endtask

  // Core side answers each fetch after a random wait
  // Sampled mid-cycle, clear of the edge that launches the pulse
  always @(negedge sys_clk)
    if (rd_req === 1'b1)
    begin
      repeat ($urandom_range(0, 4)) @(negedge sys_clk);
      push(core_w, 50, ok_c);
    end
  always @(negedge sys_clk)
    if (rd_req === 1'b1)
      take({12'h0, virt, port, be, addr});
  always @(u_host.got)
    take({24'h0, u_host.got_d});

  initial
  begin
    #2_000_000;
    bad_count++;
    end_sim();
  end

  initial
  begin
    void'($urandom(32'h6ba9));
    ta = TARGET_ADDR_BASE;
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    `CHK({sda_oe, rd_req, ready, sda_out}, 4'b0010)
    repeat (4) @(negedge sys_clk);
    core_w = 32'habcd_ef01;
    read_cmd(32'h0402_3c99, 1'b1, 1'b0);
    read_data(core_w, 6);
    for (int i = 0; i < 4; i++)
    begin
      strap = 3'($urandom);
      ta = TARGET_ADDR_BASE | {4'h0, strap};
      mode = (i == 0) ? 1'b1 : 1'($urandom);
      p = 3'($urandom_range(0, 4));
      core_w = $urandom;
      c = {5'h0, OP_READ, 5'h0, mode, p[2:1], p[0], 1'b0, 4'($urandom), 10'($urandom)};
      read_cmd(c, 1'b1, 1'b1);
      read_data(core_w, 4);
    end
    last = core_w;
    core_w = ~last;
    mode = 1'b0;
    for (int op = 0; op < 10; op++)
    begin
      c = (op < 8) ? {5'h0, 3'(op), 24'h0} : (op == 8) ? 32'h0402_8000 : 32'h0404_0000;
      if (op != 4)
      begin
        read_cmd(c, 1'b0, 1'b0);
        read_data(last, 1);
      end
    end
    read_cmd(32'h0302_3c99, 1'b0, 1'b1);
    note(32'h1);
    u_host.wr(8'h12);
    u_host.stop();
    note(32'h1);
    u_host.start();
    u_host.wr({ta ^ 7'h08, 1'b1});
    u_host.stop();
    // Words offered while sending wait in the buffer queue until it is full; the third is refused
    fork
      read_data(last, 4);
      begin
        repeat (120) @(negedge sys_clk);
        for (int k = 0; k < 3; k++)
        begin
          push(32'h1111_1111 * (k + 1), 1, ok);
          `CHK(ok, k < 2)
        end
      end
    join
    read_data(32'h2222_2222, 1);
    `CHK(ready, 1'b1)
    `CHK(exp_q.size(), 0)
    end_sim();
  end
endmodule
`default_nettype wire
